// ### logic/sesc_eq_status.sv
// Builds the sixteen equalizer status bytes: registered for the wired lanes, tied to zero for the rest.
`default_nettype none
module sesc_eq_status
  import sesc_pkg::*;
(
  // Clock and reset.
  input wire logic ref_clk,
  input wire logic rst_b,
  // Wired lane equalizer state.
  input wire logic [NUM_WIRED-1:0][15:0] thermLevel,
  input wire logic [NUM_WIRED-1:0] aboveLimit,
  input wire logic [NUM_WIRED-1:0] belowLimit,
  // Status bytes, one per physical lane.
  output logic [NUM_LANES-1:0][7:0] statusBytes
);
  genvar g;
  // Wired entries are flops; unwired lanes are tied to zero.
  for (g = 0; g < NUM_LANES; g++)
  begin : gEntry
    if (g == WIRED0 || g == WIRED1)
    begin : gWired
      localparam int W = (g == WIRED0) ? 0 : 1;
      always_ff @(posedge ref_clk or negedge rst_b)
      begin
        if (!rst_b)
          statusBytes[g] <= 8'h00;
        else
          statusBytes[g] <= {1'b0, aboveLimit[W], belowLimit[W], // [RQ3]
                             5'($countones(thermLevel[W]))}; // [RQ2]
      end
    end
    else
    begin : gOpen
      assign statusBytes[g] = 8'h00; // [RQ1]
    end
  end
endmodule : sesc_eq_status
`default_nettype wire

// ### logic/sesc_eye_scan.sv
// Eye-scan control top: AXI4-Lite register file, lane engines and equalizer status.
//
// Decided for this implementation: the AXI4-Lite interface to the registers.
`default_nettype none
module sesc_eye_scan
  import sesc_pkg::*;
(
  // Clock and reset.
  input wire logic ref_clk,
  input wire logic rst_b,
  // AXI4-Lite write address channel.
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [ADDR_W-1:0] s_axi_awaddr,
  // AXI4-Lite write data channel.
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  // AXI4-Lite write response channel.
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  output logic [1:0] s_axi_bresp,
  // AXI4-Lite read address channel.
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  input wire logic [ADDR_W-1:0] s_axi_araddr,
  // AXI4-Lite read data channel.
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  // Receiver state of the wired lanes, same clock.
  input wire logic [NUM_WIRED-1:0][15:0] laneThermLevel,
  input wire logic [NUM_WIRED-1:0] equalizerAboveLimit,
  input wire logic [NUM_WIRED-1:0] equalizerBelowLimit,
  // Sampler data of the wired lanes, same clock.
  input wire logic [NUM_WIRED-1:0] laneSampleValid,
  input wire logic [NUM_WIRED-1:0] laneNormalBit,
  input wire logic [NUM_WIRED-1:0] laneScanBit,
  // Controls toward the scan samplers.
  output logic [6:0] scanPhaseOffset,
  output logic [NUM_WIRED-1:0][5:0] laneThresholdDrive,
  output logic [NUM_WIRED-1:0] laneScanActive
);
  logic awHeldR;
  logic wHeldR;
  logic [IDX_W-1:0] awIdxR;
  logic [7:0] wDataR;
  logic wLane0R;
  logic commit;
  logic wrOk;
  logic wrReg;
  logic [7:0] runR;
  logic [7:0] setupR;
  logic [7:0] phaseR;
  logic startR;
  logic [3:0] modeLatR;
  logic [1:0] lenLatR;
  logic [IDX_W-1:0] arIdx;
  logic [31:0] rdNxt;
  logic [1:0] rrNxt;
  logic [NUM_LANES-1:0][7:0] statusBytes;
  logic [NUM_WIRED-1:0] laneDone;
  logic [NUM_WIRED-1:0][15:0] laneCount;
  logic [15:0] doneVec;
  logic aliveR;
  logic startNxt;
  sesc_scan_if cfgIf ();

  // Write channels are taken independently and held until the pair commits.
  assign s_axi_awready = !awHeldR;
  assign s_axi_wready = !wHeldR;
  assign commit = awHeldR && wHeldR && !s_axi_bvalid;
  assign wrReg = commit && wLane0R;

  // Write address holding register.
  always_ff @(posedge ref_clk or negedge rst_b)
  begin
    if (!rst_b)
    begin
      awHeldR <= 1'b0;
      awIdxR <= '0;
    end
    else if (s_axi_awvalid && s_axi_awready)
    begin
      awHeldR <= 1'b1;
      awIdxR <= s_axi_awaddr[ADDR_W-1:2];
    end
    else if (commit)
      awHeldR <= 1'b0;
  end

  // Write data holding register; only byte lane 0 carries register bits.
  always_ff @(posedge ref_clk or negedge rst_b)
  begin
    if (!rst_b)
    begin
      wHeldR <= 1'b0;
      wDataR <= 8'h00;
      wLane0R <= 1'b0;
    end
    else if (s_axi_wvalid && s_axi_wready)
    begin
      wHeldR <= 1'b1;
      wDataR <= s_axi_wdata[7:0];
      wLane0R <= s_axi_wstrb[0];
    end
    else if (commit)
      wHeldR <= 1'b0;
  end

  // Known write targets answer OKAY, read-only ones included; the rest get SLVERR.
  always_comb
  begin
    wrOk = 1'b0;
    if (awIdxR inside {[IDX_LANE_EQUALIZER_STATUS:IDX_PHASE], IDX_DONE, [IDX_THR:IDX_CNT + 10'h00f]})
      wrOk = 1'b1;
  end

  // Write response follows the commit by one edge and stands until bready.
  always_ff @(posedge ref_clk or negedge rst_b)
  begin
    if (!rst_b)
    begin
      s_axi_bvalid <= 1'b0;
      s_axi_bresp <= RESP_OKAY;
    end
    else if (commit)
    begin
      s_axi_bvalid <= 1'b1;
      s_axi_bresp <= wrOk ? RESP_OKAY : RESP_SLVERR;
    end
    else if (s_axi_bready)
      s_axi_bvalid <= 1'b0;
  end

  // A start is a write that raises the run bit from zero.
  assign startNxt = wrReg && awIdxR == IDX_RUN && wDataR[RUN_BIT] && !runR[RUN_BIT];

  // Run control register.
  always_ff @(posedge ref_clk or negedge rst_b)
  begin
    if (!rst_b)
      runR <= RUN_RST;
    else if (wrReg && awIdxR == IDX_RUN)
      runR <= wDataR; // [RQ4]
  end

  // Setup and phase registers; software keeps setup still while running.
  always_ff @(posedge ref_clk or negedge rst_b)
  begin
    if (!rst_b)
    begin
      setupR <= SETUP_RST;
      phaseR <= PHASE_RST;
    end
    else if (wrReg && awIdxR == IDX_SETUP)
      setupR <= wDataR; // [RQ5]
    else if (wrReg && awIdxR == IDX_PHASE)
      phaseR <= wDataR;
  end

  // Start pulse with the settings captured at that moment, shared by all lanes.
  always_ff @(posedge ref_clk or negedge rst_b)
  begin
    if (!rst_b)
    begin
      startR <= 1'b0;
      modeLatR <= MODE_OFF;
      lenLatR <= 2'h0;
    end
    else
    begin
      startR <= startNxt; // [RQ4]
      if (startNxt)
      begin
        modeLatR <= setupR[3:0]; // [RQ7]
        lenLatR <= setupR[LEN_LSB+1:LEN_LSB]; // [RQ6]
      end
    end
  end

  // Shared settings out to the lane engines.
  assign cfgIf.runOn = runR[RUN_BIT];
  assign cfgIf.start = startR;
  assign cfgIf.mode = modeLatR;
  assign cfgIf.lenCode = lenLatR;

  // Signed phase shift straight to the scan samplers, 1/32 UI per step.
  assign scanPhaseOffset = phaseR[6:0]; // [RQ14]

  // One independent engine per wired lane, all fed by the same settings.
  for (genvar l = 0; l < NUM_WIRED; l++)
  begin : gLane
    sesc_scan_lane uLane (
      .ref_clk(ref_clk),
      .rst_b(rst_b),
      .cfg(cfgIf.lane), // [RQ15]
      .sampleValid(laneSampleValid[l]),
      .normalBit(laneNormalBit[l]),
      .scanBit(laneScanBit[l]),
      .scanDone(laneDone[l]),
      .scanning(laneScanActive[l]),
      .mismatchCount(laneCount[l]),
      .thresholdResult(laneThresholdDrive[l])
    );
  end

  // Equalizer status bytes for all sixteen physical lanes.
  sesc_eq_status uStatus (
    .ref_clk(ref_clk),
    .rst_b(rst_b),
    .thermLevel(laneThermLevel),
    .aboveLimit(equalizerAboveLimit),
    .belowLimit(equalizerBelowLimit),
    .statusBytes(statusBytes)
  );

  // Completion flags placed at their physical lane positions.
  always_comb
  begin
    doneVec = 16'h0000;
    doneVec[WIRED0] = laneDone[0];
    doneVec[WIRED1] = laneDone[1];
  end

  // Read decode; unwired lanes read zero, unknown words get SLVERR.
  assign arIdx = s_axi_araddr[ADDR_W-1:2];
  always_comb
  begin
    rdNxt = 32'h0000_0000;
    rrNxt = RESP_OKAY;
    if (arIdx inside {[IDX_LANE_EQUALIZER_STATUS:IDX_LANE_EQUALIZER_STATUS + 10'h00f]})
      rdNxt[7:0] = statusBytes[arIdx[3:0]]; // [RQ1]
    else if (arIdx == IDX_RUN)
      rdNxt[7:0] = runR;
    else if (arIdx == IDX_SETUP)
      rdNxt[7:0] = setupR;
    else if (arIdx == IDX_PHASE)
      rdNxt[7:0] = phaseR;
    else if (arIdx == IDX_DONE)
      rdNxt[15:0] = doneVec;
    else if (arIdx inside {[IDX_THR:IDX_THR + 10'h00f]})
    begin
      if (arIdx[3:0] == 4'(WIRED0))
        rdNxt[5:0] = laneThresholdDrive[0];
      else if (arIdx[3:0] == 4'(WIRED1))
        rdNxt[5:0] = laneThresholdDrive[1];
    end
    else if (arIdx inside {[IDX_CNT:IDX_CNT + 10'h00f]})
    begin
      if (arIdx[3:0] == 4'(WIRED0))
        rdNxt[15:0] = laneCount[0];
      else if (arIdx[3:0] == 4'(WIRED1))
        rdNxt[15:0] = laneCount[1];
    end
    else
      rrNxt = RESP_SLVERR;
  end

  // Read answer is registered on the same edge that takes the address.
  assign s_axi_arready = !s_axi_rvalid;
  always_ff @(posedge ref_clk or negedge rst_b)
  begin
    if (!rst_b)
    begin
      s_axi_rvalid <= 1'b0;
      s_axi_rdata <= 32'h0000_0000;
      s_axi_rresp <= RESP_OKAY;
    end
    else if (s_axi_arvalid && s_axi_arready)
    begin
      s_axi_rvalid <= 1'b1;
      s_axi_rdata <= rdNxt;
      s_axi_rresp <= rrNxt;
    end
    else if (s_axi_rready)
      s_axi_rvalid <= 1'b0;
  end

  // Marks the cycles after the first clock edge out of reset.
  always_ff @(posedge ref_clk or negedge rst_b)
  begin
    if (!rst_b)
      aliveR <= 1'b0;
    else
      aliveR <= 1'b1;
  end

  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (!rst_b);

  // A run write with a usable mode, then the start pulse, then scanning.
  sequence runWrite_s;
    startNxt && sesc_mode_legal(setupR[3:0]);
  endsequence
  sequence scanBegins_s;
    startR ##1 (laneScanActive == 2'b11);
  endsequence

  open_lanes_a: assert property (statusBytes[0] == 8'h00 && statusBytes[15] == 8'h00
      && statusBytes[WIRED0][7] == 1'b0 && statusBytes[WIRED1][7] == 1'b0) // [RQ1]
    else $error("Unwired lane or reserved bit is nonzero.");
  eq_level_a: assert property (aliveR |->
      statusBytes[WIRED1][4:0] == 5'($countones($past(laneThermLevel[1])))) // [RQ2]
    else $error("Level field is not the thermometer population count.");
  eq_flags_a: assert property (aliveR |->
      statusBytes[WIRED0][OVER_BIT] == $past(equalizerAboveLimit[0])
      && statusBytes[WIRED0][UNDER_BIT] == $past(equalizerBelowLimit[0])) // [RQ3]
    else $error("Over or under flag does not follow the lane.");
  run_start_a: assert property (runWrite_s |=> scanBegins_s) // [RQ4]
    else $error("Run write did not start the scan.");
  mode_off_a: assert property (startNxt && setupR[3:0] == MODE_OFF
      |=> ##1 laneScanActive == 2'b00 [*3]) // [RQ7]
    else $error("Off mode started a scan.");
  len_latch_a: assert property (startNxt |=> lenLatR == $past(setupR[LEN_LSB+1:LEN_LSB])) // [RQ6]
    else $error("Length code not captured at start.");
  phase_out_a: assert property (wrReg && awIdxR == IDX_PHASE
      |=> scanPhaseOffset == $past(wDataR[6:0])) // [RQ14]
    else $error("Phase shift not driven to the samplers.");
  lanes_start_a: assert property ($rose(laneScanActive[0]) == $rose(laneScanActive[1])) // [RQ15]
    else $error("Wired lanes did not start together.");
  ab_once_a: assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid)
    else $error("Write response dropped before bready.");
endmodule : sesc_eye_scan
`default_nettype wire

// ### logic/sesc_pkg.sv
// Constants, types and helpers shared by the eye-scan control block.
// Functional notes
// RQ1 - Each of the sixteen lanes has a read-only equalizer status byte; only lanes 6 and 14 are wired.
// RQ2 - The level field reports how many bits are set in the lane's thermometer-coded level.
// RQ3 - Each status byte shows the lane's above-limit and below-limit flags from cursor analysis.
// RQ4 - Writing 1 to the run bit after setup starts the eye scan on the lanes.
// RQ5 - Software changes the setup register only while the run bit is clear.
// RQ6 - The length field picks 127, 1032, 8191 or 65535 analyzed samples for codes 0 to 3.
// RQ7 - The mode field applies to all lanes, code 0 turns scanning off, and 5-7, 11, 15 are unused.
// RQ8 - Mode 1 counts sampler mismatches on all bits, mode 2 only on zeros, mode 3 only on ones.
// RQ9 - Mode 4 bumps the lane counter whenever the scan sampler sees a one.
// RQ10 - Modes 8, 9, 10 move the threshold to the average, lowest, highest level of a zero.
// RQ11 - Modes 12, 13, 14 move the threshold to the average, highest, lowest level of a one.
// RQ12 - Modes that look at only zeros or only ones take longer for the same sample count.
// RQ13 - Software checks the lane's complete flag before reading its threshold or counter.
// RQ14 - The signed phase shift moves the scan sampler in steps of 1/32 UI.
// RQ15 - On run, every wired lane scans at once and on its own with the shared settings.
`default_nettype none
package sesc_pkg;
  localparam int ADDR_W = 12;
  localparam int IDX_W = 10;
  localparam logic [IDX_W-1:0] IDX_LANE_EQUALIZER_STATUS = 10'h1e0;
  localparam logic [IDX_W-1:0] IDX_RUN = 10'h1f0;
  localparam logic [IDX_W-1:0] IDX_SETUP = 10'h1f1;
  localparam logic [IDX_W-1:0] IDX_PHASE = 10'h1f2;
  localparam logic [IDX_W-1:0] IDX_DONE = 10'h1f6;
  localparam logic [IDX_W-1:0] IDX_THR = 10'h200;
  localparam logic [IDX_W-1:0] IDX_CNT = 10'h210;
  localparam int NUM_LANES = 16;
  localparam int NUM_WIRED = 2;
  localparam int WIRED0 = 6;
  localparam int WIRED1 = 14;
  localparam logic [7:0] RUN_RST = 8'h00;
  localparam logic [7:0] SETUP_RST = 8'h00;
  localparam logic [7:0] PHASE_RST = 8'h00;
  localparam int RUN_BIT = 0;
  localparam int LEN_LSB = 4;
  localparam int OVER_BIT = 6;
  localparam int UNDER_BIT = 5;
  localparam logic [15:0] LEN_C0 = 16'h007f;
  localparam logic [15:0] LEN_C1 = 16'h0408;
  localparam logic [15:0] LEN_C2 = 16'h1fff;
  localparam logic [15:0] LEN_C3 = 16'hffff;
  localparam logic [3:0] MODE_OFF = 4'h0;
  localparam logic [3:0] MODE_CMP = 4'h1;
  localparam logic [3:0] MODE_CMP_ZERO = 4'h2;
  localparam logic [3:0] MODE_CMP_ONE = 4'h3;
  localparam logic [3:0] MODE_CNT_ONE = 4'h4;
  localparam logic [3:0] MODE_AVG_ZERO = 4'h8;
  localparam logic [3:0] MODE_LOW_ZERO = 4'h9;
  localparam logic [3:0] MODE_HIGH_ZERO = 4'ha;
  localparam logic [3:0] MODE_AVG_ONE = 4'hc;
  localparam logic [3:0] MODE_HIGH_ONE = 4'hd;
  localparam logic [3:0] MODE_LOW_ONE = 4'he;
  localparam logic [5:0] THR_MAX = 6'h1f;
  localparam logic [5:0] THR_MIN = 6'h20;
  localparam logic [5:0] THR_RST = 6'h00;
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;
  typedef enum logic [2:0] {ST_IDLE = 3'b001, ST_SCAN = 3'b010, ST_DONE = 3'b100} sesc_lane_e;

  // Number of analyzed samples for each length code.
  function automatic logic [15:0] sesc_len_target(input logic [1:0] code);
    return (code == 2'h0) ? LEN_C0 : (code == 2'h1) ? LEN_C1 : (code == 2'h2) ? LEN_C2 : LEN_C3;
  endfunction : sesc_len_target

  // True for modes that run; off and unused codes stay idle.
  function automatic logic sesc_mode_legal(input logic [3:0] m);
    return (m inside {[4'h1:4'h4], [4'h8:4'ha], [4'hc:4'he]});
  endfunction : sesc_mode_legal

  // True for modes that analyze zeros only.
  function automatic logic sesc_mode_zeros(input logic [3:0] m);
    return (m inside {MODE_CMP_ZERO, [MODE_AVG_ZERO:MODE_HIGH_ZERO]});
  endfunction : sesc_mode_zeros

  // True for modes that analyze ones only.
  function automatic logic sesc_mode_ones(input logic [3:0] m);
    return (m inside {MODE_CMP_ONE, [MODE_AVG_ONE:MODE_LOW_ONE]});
  endfunction : sesc_mode_ones
endpackage : sesc_pkg
`default_nettype wire

// ### logic/sesc_scan_if.sv
// Shared scan settings passed from the register file to every lane engine.
`default_nettype none
interface sesc_scan_if;
  logic runOn;
  logic start;
  logic [3:0] mode;
  logic [1:0] lenCode;
  modport ctrl (output runOn, output start, output mode, output lenCode);
  modport lane (input runOn, input start, input mode, input lenCode);
endinterface : sesc_scan_if
`default_nettype wire

// ### logic/sesc_scan_lane.sv
// Eye-scan engine for one wired lane: qualifies samples, counts and tracks the threshold.
`default_nettype none
module sesc_scan_lane
  import sesc_pkg::*;
(
  // Clock and reset.
  input wire logic ref_clk,
  input wire logic rst_b,
  // Shared settings.
  sesc_scan_if.lane cfg,
  // Sampler outputs of this lane.
  input wire logic sampleValid,
  input wire logic normalBit,
  input wire logic scanBit,
  // Results.
  output logic scanDone,
  output logic scanning,
  output logic [15:0] mismatchCount,
  output logic [5:0] thresholdResult
);
  sesc_lane_e stateR;
  logic [15:0] analyzedR;
  logic qualify;
  logic hit;
  logic stepUp;
  logic stepDown;

  // A sample counts only if the mode looks at its bit value; split modes run longer.
  assign qualify = sampleValid && stateR == ST_SCAN &&
                   (sesc_mode_zeros(cfg.mode) ? !normalBit :
                    sesc_mode_ones(cfg.mode) ? normalBit : 1'b1); // [RQ12]
  assign hit = (cfg.mode == MODE_CNT_ONE) ? scanBit : // [RQ9]
               (cfg.mode <= MODE_CMP_ONE) && (scanBit != normalBit); // [RQ8]
  assign stepUp = scanBit && cfg.mode inside {MODE_AVG_ZERO, MODE_HIGH_ZERO,
                                              MODE_AVG_ONE, MODE_HIGH_ONE};
  assign stepDown = !scanBit && cfg.mode inside {MODE_AVG_ZERO, MODE_LOW_ZERO,
                                                 MODE_AVG_ONE, MODE_LOW_ONE};
  assign scanDone = stateR == ST_DONE;
  assign scanning = stateR == ST_SCAN;

  // Lane sequencer; an unused or off mode never leaves idle, a cleared run aborts.
  always_ff @(posedge ref_clk or negedge rst_b)
  begin
    if (!rst_b)
      stateR <= ST_IDLE;
    else if (cfg.start)
      stateR <= sesc_mode_legal(cfg.mode) ? ST_SCAN : ST_IDLE; // [RQ7] [RQ15]
    else
      unique case (stateR)
        ST_IDLE: stateR <= ST_IDLE;
        ST_SCAN:
          if (!cfg.runOn)
            stateR <= ST_IDLE;
          else if (qualify && analyzedR == sesc_len_target(cfg.lenCode) - 16'h0001)
            stateR <= ST_DONE; // [RQ6]
        ST_DONE: stateR <= ST_DONE;
      endcase
  end

  // Analyzed-sample and mismatch counters, cleared at each start; count saturates.
  always_ff @(posedge ref_clk or negedge rst_b)
  begin
    if (!rst_b)
    begin
      analyzedR <= 16'h0000;
      mismatchCount <= 16'h0000;
    end
    else if (cfg.start)
    begin
      analyzedR <= 16'h0000;
      mismatchCount <= 16'h0000;
    end
    else if (qualify)
    begin
      analyzedR <= analyzedR + 16'h0001;
      if (hit && mismatchCount != 16'hffff)
        mismatchCount <= mismatchCount + 16'h0001; // [RQ8] [RQ9]
    end
  end

  // Threshold tracking for the voltage-seeking modes, saturating at the signed range.
  always_ff @(posedge ref_clk or negedge rst_b)
  begin
    if (!rst_b)
      thresholdResult <= THR_RST;
    else if (cfg.start)
      thresholdResult <= THR_RST;
    else if (qualify && stepUp && thresholdResult != THR_MAX)
      thresholdResult <= thresholdResult + 6'h01; // [RQ10] [RQ11]
    else if (qualify && stepDown && thresholdResult != THR_MIN)
      thresholdResult <= thresholdResult - 6'h01; // [RQ10] [RQ11]
  end

  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (!rst_b);

  len_done_a: assert property ($rose(scanDone) |-> analyzedR == sesc_len_target(cfg.lenCode)) // [RQ6]
    else $error("Scan finished at the wrong sample count.");
  mode_idle_a: assert property (scanning |-> sesc_mode_legal(cfg.mode)) // [RQ7]
    else $error("Lane scans in an off or unused mode.");
  cmp_count_a: assert property (qualify && cfg.mode == MODE_CMP && scanBit != normalBit
      && mismatchCount != 16'hffff && !cfg.start |=> mismatchCount == $past(mismatchCount) + 16'h0001) // [RQ8]
    else $error("Compare mismatch not counted.");
  ones_count_a: assert property (qualify && cfg.mode == MODE_CNT_ONE && !scanBit && !cfg.start
      |=> mismatchCount == $past(mismatchCount)) // [RQ9]
    else $error("Count-ones mode counted a zero.");
  low_zero_a: assert property (scanning && cfg.mode == MODE_LOW_ZERO && !cfg.start
      |=> $signed(thresholdResult) <= $signed($past(thresholdResult))) // [RQ10]
    else $error("Lowest-zero search moved upward.");
  high_one_a: assert property (scanning && cfg.mode == MODE_HIGH_ONE && !cfg.start
      |=> $signed(thresholdResult) >= $signed($past(thresholdResult))) // [RQ11]
    else $error("Highest-one search moved downward.");
  zero_only_a: assert property (sampleValid && normalBit && cfg.mode == MODE_CMP_ZERO && !cfg.start
      |=> analyzedR == $past(analyzedR)) // [RQ12]
    else $error("Zeros-only mode analyzed a one.");
endmodule : sesc_scan_lane
`default_nettype wire

// ### sim/serdes_eye_scan_control_tb.sv
// Self-checking testbench for the eye-scan control block.
`default_nettype none
module serdes_eye_scan_control_tb
  import sesc_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;
  typedef struct {logic [15:0] th; logic up; logic dn; logic [7:0] ex;} sesc_row_s;
  typedef struct {logic [7:0] su; int n; logic sb; logic [15:0] cnt; logic [5:0] thr;} sesc_scan_s;
  // Bus, lane and bookkeeping signals; bready and rready stay high throughout.
  logic ref_clk = 1'b0, rst_b = 1'b1, s_axi_bready = 1'b1, s_axi_rready = 1'b1;
  logic s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_arvalid = 1'b0;
  logic [ADDR_W-1:0] s_axi_awaddr = '0, s_axi_araddr = '0;
  logic [31:0] s_axi_wdata = '0, s_axi_rdata, rd;
  logic [3:0] s_axi_wstrb = 4'h0;
  logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
  logic [1:0] s_axi_bresp, s_axi_rresp, rsp;
  logic [NUM_WIRED-1:0][15:0] laneThermLevel = '0;
  logic [NUM_WIRED-1:0] equalizerAboveLimit = '0, equalizerBelowLimit = '0;
  logic [NUM_WIRED-1:0] laneSampleValid = '0, laneNormalBit = '0, laneScanBit = '0;
  logic [NUM_WIRED-1:0] laneScanActive;
  logic [6:0] scanPhaseOffset;
  logic [NUM_WIRED-1:0][5:0] laneThresholdDrive;
  int nErrors = 0, testsRun = 0, cycles = 0;
  int lanes [2] = '{WIRED0, WIRED1};
  int badModes [4] = '{0, 5, 11, 15};
  sesc_row_s rows [4] = '{'{16'h0000, 1'b0, 1'b0, 8'h00}, '{16'hffff, 1'b1, 1'b0, 8'h50},
    '{16'h00ff, 1'b0, 1'b1, 8'h28}, '{16'h0007, 1'b1, 1'b1, 8'h63}};
  // Scan cases on alternating normal bits: setup, samples, scan bit, count, threshold.
  sesc_scan_s scans [4] = '{'{8'h01, 127, 1'b1, 16'h0040, 6'h00},
    '{8'h14, 1032, 1'b1, 16'h0408, 6'h00}, '{8'h0d, 254, 1'b1, 16'h0000, 6'h1f},
    '{8'h03, 254, 1'b0, 16'h007f, 6'h00}};

  sesc_eye_scan uut (.ref_clk, .rst_b, .s_axi_awvalid, .s_axi_awready, .s_axi_awaddr,
    .s_axi_wvalid, .s_axi_wready, .s_axi_wdata, .s_axi_wstrb, .s_axi_bvalid, .s_axi_bready,
    .s_axi_bresp, .s_axi_arvalid, .s_axi_arready, .s_axi_araddr, .s_axi_rvalid, .s_axi_rready,
    .s_axi_rdata, .s_axi_rresp, .laneThermLevel, .equalizerAboveLimit, .equalizerBelowLimit,
    .laneSampleValid, .laneNormalBit, .laneScanBit, .scanPhaseOffset, .laneThresholdDrive,
    .laneScanActive);

  // The clock toggles every half period of 25 ns.
  always #25 ref_clk = ~ref_clk;

  // Prints the verdict and stops the run.
  task automatic endSim();
    if (nErrors == 0 && testsRun > 0)
      $display("[ PASS ]");
    else
      $display("[ FAIL ]");
    $finish;
  endtask : endSim

  // A hung handshake is cut short and counted as a mismatch.
  always @(posedge ref_clk)
  begin
    cycles = cycles + 1;
    if (cycles == 5000)
    begin
      nErrors = nErrors + 1;
      endSim();
    end
  end

  // Compares one value and reports a mismatch at once.
  task automatic chk(input string nm, input logic [31:0] ex, input logic [31:0] got);
    testsRun++;
    if (got !== ex)
    begin
      $display("Error %s expected %h got %h", nm, ex, got);
      nErrors++;
    end
  endtask : chk

  // Writes one register word; handshakes are sampled at the falling edge before acting.
  task automatic wr(input logic [9:0] idx, input logic [7:0] d);
    logic a, w, b;
    s_axi_awaddr <= {idx, 2'b00};
    s_axi_wdata <= {24'h0, d};
    s_axi_wstrb <= 4'h1;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    b = 1'b0;
    while (!b)
    begin
      @(negedge ref_clk);
      a = s_axi_awready;
      w = s_axi_wready;
      b = s_axi_bvalid;
      rsp = s_axi_bresp;
      @(posedge ref_clk);
      if (a && s_axi_awvalid) s_axi_awvalid <= 1'b0;
      if (w && s_axi_wvalid) s_axi_wvalid <= 1'b0;
    end
    chk("bresp", 32'(RESP_OKAY), 32'(rsp));
  endtask : wr

  // Reads one register word into rd and its response into rsp.
  task automatic rdr(input logic [9:0] idx);
    logic a, v;
    s_axi_araddr <= {idx, 2'b00};
    s_axi_arvalid <= 1'b1;
    v = 1'b0;
    while (!v)
    begin
      @(negedge ref_clk);
      a = s_axi_arready;
      v = s_axi_rvalid;
      rd = s_axi_rdata;
      rsp = s_axi_rresp;
      @(posedge ref_clk);
      if (a && s_axi_arvalid) s_axi_arvalid <= 1'b0;
    end
  endtask : rdr

  // Sends n samples on both lanes, one a cycle; alt makes the normal bit alternate 0,1.
  task automatic feed(input int n, input logic alt, input logic sb);
    for (int i = 0; i < n; i++)
    begin
      laneSampleValid <= 2'b11;
      laneNormalBit <= {2{alt & i[0]}};
      laneScanBit <= {2{sb}};
      @(posedge ref_clk);
    end
    laneSampleValid <= 2'b00;
  endtask : feed

  // Stops any run, loads the setup byte and starts a new run.
  task automatic scan(input logic [7:0] setup);
    wr(IDX_RUN, 8'h00);
    wr(IDX_SETUP, setup);
    wr(IDX_RUN, 8'h01);
    repeat (3) @(posedge ref_clk);
  endtask : scan

  // Main sequence.
  initial
  begin
    rst_b <= 1'b0;
    repeat (4) @(posedge ref_clk);
    rst_b <= 1'b1;
    @(posedge ref_clk);
    rdr(IDX_RUN);
    chk("run reset", 32'(RUN_RST), rd);
    rdr(IDX_SETUP);
    chk("setup reset", 32'(SETUP_RST), rd);
    rdr(IDX_PHASE);
    chk("phase reset", 32'(PHASE_RST), rd);
    foreach (rows[r])
    begin
      laneThermLevel <= {2{rows[r].th}};
      equalizerAboveLimit <= {2{rows[r].up}};
      equalizerBelowLimit <= {2{rows[r].dn}};
      repeat (2) @(posedge ref_clk);
      foreach (lanes[k])
      begin
        rdr(IDX_LANE_EQUALIZER_STATUS + 10'(lanes[k]));
        chk("status", 32'(rows[r].ex), rd);
      end
    end
    rdr(IDX_LANE_EQUALIZER_STATUS);
    chk("open lane", 32'h0, rd);
    wr(IDX_PHASE, 8'h40);
    rdr(IDX_PHASE);
    chk("phase", 32'h40, 32'(rd[6:0]));
    chk("phase pin", 32'h40, 32'(scanPhaseOffset));
    rdr(10'h3ff);
    chk("unmapped", 32'(RESP_SLVERR), 32'(rsp));
    // Zeros-only compare: 127 zeros need 253 alternating samples.
    scan(8'h02);
    chk("active", 32'h3, 32'(laneScanActive));
    feed(252, 1'b1, 1'b1);
    @(posedge ref_clk);
    chk("still active", 32'h3, 32'(laneScanActive));
    feed(1, 1'b1, 1'b1);
    repeat (3) @(posedge ref_clk);
    chk("finished", 32'h0, 32'(laneScanActive));
    rdr(IDX_DONE);
    chk("done", 32'h4040, rd & 32'h4040);
    foreach (lanes[k])
    begin
      rdr(IDX_CNT + 10'(lanes[k]));
      chk("mismatch count", 32'h7f, 32'(rd[15:0]));
    end
    rdr(IDX_SETUP);
    chk("setup", 32'h02, rd);
    // Lowest zero level: every zero sample pulls the threshold down until it saturates.
    scan(8'h09);
    feed(127, 1'b0, 1'b0);
    repeat (3) @(posedge ref_clk);
    rdr(IDX_THR + 10'(WIRED1));
    chk("threshold", 32'h20, 32'(rd[5:0]));
    chk("threshold pin", 32'h820, 32'(laneThresholdDrive));
    foreach (scans[s])
    begin
      scan(scans[s].su);
      feed(scans[s].n, 1'b1, scans[s].sb);
      repeat (3) @(posedge ref_clk);
      rdr(IDX_DONE);
      chk("scan done", 32'h4040, rd & 32'h4040);
      rdr(IDX_CNT + 10'(WIRED0));
      chk("scan count", 32'(scans[s].cnt), rd);
      rdr(IDX_THR + 10'(WIRED1));
      chk("scan threshold", 32'(scans[s].thr), rd);
    end
    foreach (badModes[m])
    begin
      scan({4'h0, 4'(badModes[m])});
      chk("idle mode", 32'h0, 32'(laneScanActive));
    end
    // A reset in mid-scan returns the lanes and the registers to idle.
    scan(8'h01);
    rst_b <= 1'b0;
    @(posedge ref_clk);
    rst_b <= 1'b1;
    @(posedge ref_clk);
    chk("reset active", 32'h0, 32'(laneScanActive));
    rdr(IDX_RUN);
    chk("run after reset", 32'(RUN_RST), rd);
    rdr(IDX_SETUP);
    chk("setup after reset", 32'(SETUP_RST), rd);
    endSim();
  end
endmodule : serdes_eye_scan_control_tb
`default_nettype wire
